/* File: logic/pste_top.sv */
// Power state transition event arbiter with an APB register slave.
// Assumes event inputs are synchronous one-cycle-or-longer levels on pclk.
`timescale 1ns/1ps
module pste_top #(
  parameter int NGPIO = 4,
  parameter int NREG = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_alarm,
  input wire logic [NGPIO-1:0] gpio_req,
  input wire logic [NGPIO*3-1:0] gpio_func,
  input wire logic button_asserted,
  input wire logic watchdog_timeout,
  input wire logic hw_reset_req,
  input wire logic [NREG-1:0] reg_undervoltage,
  input wire logic low_supply_threshold,
  input wire logic shutdown_threshold,
  input wire logic supply_ok_threshold,
  input wire logic thermal_shutdown,
  input wire logic startup_timeout,
  input wire logic internal_regulator_fault,
  output logic [1:0] power_state,
  output logic on_pulse,
  output logic off_pulse,
  output logic sleep_pulse,
  output logic wake_pulse
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [5:0] cfg_r;
  logic [NREG-1:0] uvcfg_r;
  logic [15:0] on_src_r, on_src_nxt;
  logic [15:0] off_src_r, off_src_nxt;
  pste_pkg::pste_state_t st_r, st_nxt;
  logic on_r, off_r, sleep_r, wake_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == pste_pkg::ADDR_CTRL);
  wire hit_cfg = (paddr == pste_pkg::ADDR_CFG);
  wire hit_on = (paddr == pste_pkg::ADDR_ON_SRC);
  wire hit_off = (paddr == pste_pkg::ADDR_OFF_SRC);
  wire hit_st = (paddr == pste_pkg::ADDR_STATE);
  wire hit_uv = (paddr == pste_pkg::ADDR_UVCFG);
  wire mapped = hit_ctrl | hit_cfg | hit_on | hit_off | hit_st | hit_uv;
  wire wr_ctrl = wr & hit_ctrl & pstrb[0];
  wire wr_cfg = wr & hit_cfg & pstrb[0];
  wire wr_uv = wr & hit_uv & pstrb[0];

  // Software requests come from the written value, not the stored one
  // Stored sleep bit is stale after a hardware wake, so it is not compared
  wire sw_sleep_req = wr_ctrl & pwdata[pste_pkg::CTRL_SLEEP];
  wire sw_wake_req = wr_ctrl & ~pwdata[pste_pkg::CTRL_SLEEP];
  wire sw_off_req = wr_ctrl & ~pwdata[pste_pkg::CTRL_CHIP_ON];
  wire sw_on_req = wr_ctrl & pwdata[pste_pkg::CTRL_CHIP_ON];
  wire sw_rst_req = wr_ctrl & pwdata[pste_pkg::CTRL_SW_RESET];

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire [1:0] btn_cfg = cfg_r[pste_pkg::CFG_BTN_LSB +: 2];
  wire [1:0] wdog_cfg = cfg_r[pste_pkg::CFG_WDOG_LSB +: 2];
  wire [1:0] sup_cfg = cfg_r[pste_pkg::CFG_SUPPLY_LSB +: 2];

  // Any GPIO whose function matches and that requests
  function automatic logic gpio_any(input logic [NGPIO-1:0] req,
                                    input logic [NGPIO*3-1:0] fn,
                                    input logic [2:0] code_a,
                                    input logic [2:0] code_b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NGPIO; i++) begin
      if (req[i] && (fn[i*3 +: 3] == code_a || fn[i*3 +: 3] == code_b)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Event classification
  // ----------------------------------------------------------------
  wire gp_on = gpio_any(gpio_req, gpio_func, pste_pkg::GPF_ON, pste_pkg::GPF_ONOFF);
  wire gp_sleep = gpio_any(gpio_req, gpio_func, pste_pkg::GPF_SLEEP, pste_pkg::GPF_SLEEPWAKE);
  wire gp_wake = gpio_any(gpio_req, gpio_func, pste_pkg::GPF_SLEEPWAKE, pste_pkg::GPF_SLEEPWAKE);
  wire gp_off = gpio_any(gpio_req, gpio_func, pste_pkg::GPF_ONOFF, pste_pkg::GPF_ONOFF);
  wire btn_on = button_asserted & (btn_cfg == pste_pkg::BTN_ON);
  wire btn_wake = button_asserted & (btn_cfg == pste_pkg::BTN_WAKE);
  wire btn_off = button_asserted & (btn_cfg == pste_pkg::BTN_OFF);
  wire wd_wake = watchdog_timeout & (wdog_cfg == pste_pkg::WDOG_WAKE);
  wire wd_rst = watchdog_timeout & (wdog_cfg == pste_pkg::WDOG_RESET);
  wire ls_wake = low_supply_threshold & (sup_cfg == pste_pkg::SUP_WAKE);
  wire ls_off = low_supply_threshold & (sup_cfg == pste_pkg::SUP_OFF);
  wire cnv_uv = |(reg_undervoltage & uvcfg_r);

  // OFF group while ON or SLEEP
  wire live = (st_r == pste_pkg::PST_ON) | (st_r == pste_pkg::PST_SLEEP);
  wire rst_ev = live & (wd_rst | hw_reset_req | sw_rst_req | cnv_uv);
  wire in_off_st = live & (sw_off_req | btn_off | thermal_shutdown | ls_off |
                           gp_off | startup_timeout | internal_regulator_fault);
  // Shutdown threshold acts in every live state regardless of config
  wire off_ev = in_off_st | (live & shutdown_threshold);
  // ON group only from OFF, gated by supply OK
  wire on_cause = rtc_alarm | gp_on | btn_on | sw_on_req;
  wire on_ev = (st_r == pste_pkg::PST_OFF) & on_cause & supply_ok_threshold;
  wire in_sleep = st_r == pste_pkg::PST_SLEEP;
  wire wake_ev = in_sleep & (sw_wake_req | wd_wake | rtc_alarm | gp_wake | ls_wake | btn_wake);
  wire sleep_ev = (st_r == pste_pkg::PST_ON) & (sw_sleep_req | gp_sleep);
  // A pending reset restarts once supply is OK
  wire rst_on = (st_r == pste_pkg::PST_RESET) & supply_ok_threshold;

  // ----------------------------------------------------------------
  // Next state and cause records; priority reset > off > wake > sleep
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    on_src_nxt = on_src_r;
    off_src_nxt = off_src_r;
    if (rst_ev) begin
      st_nxt = pste_pkg::PST_RESET;
      on_src_nxt = pste_pkg::SRC_RESET;
      on_src_nxt[pste_pkg::ON_WDRST_BIT] = wd_rst;
      on_src_nxt[pste_pkg::ON_HWRST_BIT] = hw_reset_req;
      on_src_nxt[pste_pkg::ON_SWRST_BIT] = sw_rst_req;
      on_src_nxt[pste_pkg::ON_CNVUV_BIT] = cnv_uv;
    end else if (off_ev) begin
      st_nxt = pste_pkg::PST_OFF;
      off_src_nxt = pste_pkg::SRC_RESET;
      off_src_nxt[pste_pkg::OFF_SW_BIT] = sw_off_req;
      off_src_nxt[pste_pkg::OFF_BTN_BIT] = btn_off;
      off_src_nxt[pste_pkg::OFF_TEMP_BIT] = thermal_shutdown;
      off_src_nxt[pste_pkg::OFF_SUPPLY_BIT] = ls_off | shutdown_threshold;
      off_src_nxt[pste_pkg::OFF_GPIO_BIT] = gp_off;
      off_src_nxt[pste_pkg::OFF_SEQ_BIT] = startup_timeout;
      off_src_nxt[pste_pkg::OFF_INTREG_BIT] = internal_regulator_fault;
    end else if (on_ev) begin
      st_nxt = pste_pkg::PST_ON;
      on_src_nxt = pste_pkg::SRC_RESET;
      on_src_nxt[pste_pkg::ON_TRANSITION_FLAG_BIT] = 1'b1;
      on_src_nxt[pste_pkg::ON_ALARM_BIT] = rtc_alarm;
      on_src_nxt[pste_pkg::ON_GPIO_BIT] = gp_on;
      on_src_nxt[pste_pkg::ON_BTN_BIT] = btn_on;
    end else if (rst_on) begin
      st_nxt = pste_pkg::PST_ON;
    end else if (wake_ev) begin
      st_nxt = pste_pkg::PST_ON;
      on_src_nxt = pste_pkg::SRC_RESET;
      on_src_nxt[pste_pkg::ON_SW_BIT] = sw_wake_req;
      on_src_nxt[pste_pkg::ON_WDOG_BIT] = wd_wake;
      on_src_nxt[pste_pkg::ON_ALARM_BIT] = rtc_alarm;
      on_src_nxt[pste_pkg::ON_GPIO_BIT] = gp_wake;
      on_src_nxt[pste_pkg::ON_LOWSUP_BIT] = ls_wake;
      on_src_nxt[pste_pkg::ON_BTN_BIT] = btn_wake;
    end else if (sleep_ev) begin
      st_nxt = pste_pkg::PST_SLEEP;  // records untouched
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl_r} :
    hit_cfg ? {26'h0, cfg_r} :
    hit_on ? {16'h0, on_src_r} :
    hit_off ? {16'h0, off_src_r} :
    hit_st ? {30'h0, st_r} :
    hit_uv ? 32'(uvcfg_r) : 32'h0000_0000;

  // Software-writable registers; reset bit self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pste_pkg::CTRL_RESET[2:0];
      cfg_r <= pste_pkg::CFG_RESET[5:0];
      uvcfg_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {1'b0, pwdata[1:0]};
      end
      if (wr_cfg) begin
        cfg_r <= pwdata[5:0];
      end
      if (wr_uv) begin
        uvcfg_r <= pwdata[NREG-1:0];
      end
    end
  end

  // State, records and transition pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pste_pkg::PST_OFF;
      on_src_r <= pste_pkg::SRC_RESET;
      off_src_r <= pste_pkg::SRC_RESET;
      on_r <= 1'b0;
      off_r <= 1'b0;
      sleep_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      on_src_r <= on_src_nxt;
      off_src_r <= off_src_nxt;
      on_r <= on_ev | (~rst_ev & ~off_ev & rst_on);
      off_r <= rst_ev | off_ev;
      sleep_r <= ~rst_ev & ~off_ev & ~on_ev & ~rst_on & ~wake_ev & sleep_ev;
      wake_r <= ~rst_ev & ~off_ev & ~on_ev & ~rst_on & wake_ev;
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  assign pready = 1'b1;
  assign power_state = st_r;
  assign on_pulse = on_r;
  assign off_pulse = off_r;
  assign sleep_pulse = sleep_r;
  assign wake_pulse = wake_r;
endmodule

/* File: logic/pste_pkg.sv */
// Package for the power state transition event arbiter.
// Assumes a single APB clock domain; no other package is used.
package pste_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG = 12'h004;
  localparam logic [11:0] ADDR_ON_SRC = 12'h008;
  localparam logic [11:0] ADDR_OFF_SRC = 12'h00C;
  localparam logic [11:0] ADDR_STATE = 12'h010;
  localparam logic [11:0] ADDR_UVCFG = 12'h014;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_CHIP_ON = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_SW_RESET = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Configuration register fields
  localparam int CFG_BTN_LSB = 0;
  localparam int CFG_WDOG_LSB = 2;
  localparam int CFG_SUPPLY_LSB = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Button action codes
  localparam logic [1:0] BTN_IGNORE = 2'b00;
  localparam logic [1:0] BTN_ON = 2'b01;
  localparam logic [1:0] BTN_OFF = 2'b10;
  localparam logic [1:0] BTN_WAKE = 2'b11;
  // Watchdog action codes
  localparam logic [1:0] WDOG_NONE = 2'b00;
  localparam logic [1:0] WDOG_WAKE = 2'b01;
  localparam logic [1:0] WDOG_RESET = 2'b10;
  // Supply monitor action codes
  localparam logic [1:0] SUP_NONE = 2'b00;
  localparam logic [1:0] SUP_WAKE = 2'b01;
  localparam logic [1:0] SUP_OFF = 2'b10;

  // GPIO function codes
  localparam logic [2:0] GPF_NONE = 3'd0;
  localparam logic [2:0] GPF_ON = 3'd1;
  localparam logic [2:0] GPF_ONOFF = 3'd2;
  localparam logic [2:0] GPF_SLEEP = 3'd3;
  localparam logic [2:0] GPF_SLEEPWAKE = 3'd4;

  // ----------------------------------------------------------------
  // ON-source record bit positions
  // ----------------------------------------------------------------
  localparam int ON_TRANSITION_FLAG_BIT = 15;
  localparam int ON_GPIO_BIT = 9;
  localparam int ON_LOWSUP_BIT = 8;
  localparam int ON_WDOG_BIT = 7;
  localparam int ON_SW_BIT = 6;
  localparam int ON_ALARM_BIT = 5;
  localparam int ON_BTN_BIT = 4;
  localparam int ON_CNVUV_BIT = 3;
  localparam int ON_SWRST_BIT = 2;
  localparam int ON_HWRST_BIT = 1;
  localparam int ON_WDRST_BIT = 0;
  // OFF-source record bit positions
  localparam int OFF_INTREG_BIT = 13;
  localparam int OFF_SEQ_BIT = 12;
  localparam int OFF_GPIO_BIT = 11;
  localparam int OFF_SUPPLY_BIT = 10;
  localparam int OFF_TEMP_BIT = 9;
  localparam int OFF_SW_BIT = 6;
  localparam int OFF_BTN_BIT = 4;
  localparam logic [15:0] SRC_RESET = 16'h0000;

  // Power states, Gray coded along OFF -> ON -> SLEEP
  typedef enum logic [1:0] {
    PST_OFF = 2'b00,
    PST_ON = 2'b01,
    PST_SLEEP = 2'b11,
    PST_RESET = 2'b10
  } pste_state_t;
endpackage

/* File: testbench/pste_checker.sv */
// Temporal checks on the transition outputs of the event arbiter.
// Assumes it is bound to pste_top and sees only that module's ports.
`timescale 1ns/1ps
module pste_checker #(
  parameter int NGPIO = 4,
  parameter int NREG = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic rtc_alarm,
  input wire logic [NGPIO-1:0] gpio_req,
  input wire logic button_asserted,
  input wire logic watchdog_timeout,
  input wire logic hw_reset_req,
  input wire logic [NREG-1:0] reg_undervoltage,
  input wire logic low_supply_threshold,
  input wire logic shutdown_threshold,
  input wire logic supply_ok_threshold,
  input wire logic thermal_shutdown,
  input wire logic startup_timeout,
  input wire logic internal_regulator_fault,
  input wire logic [1:0] power_state,
  input wire logic on_pulse,
  input wire logic off_pulse,
  input wire logic sleep_pulse,
  input wire logic wake_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // State decode and quiet inputs; reset sources outrank everything else
  wire st_off = power_state == pste_pkg::PST_OFF;
  wire st_on = power_state == pste_pkg::PST_ON;
  wire st_slp = power_state == pste_pkg::PST_SLEEP;
  wire st_rst = power_state == pste_pkg::PST_RESET;
  wire no_rst = !psel && !hw_reset_req && !watchdog_timeout && reg_undervoltage == '0;
  wire quiet = no_rst && !shutdown_threshold && !thermal_shutdown && !startup_timeout
    && !internal_regulator_fault && !low_supply_threshold;

  // Two steps of a reset-type event
  sequence s_reset_off;
    off_pulse && st_rst;
  endsequence
  sequence s_restart;
    on_pulse && st_on;
  endsequence

  a_alarm_on: assert property (st_off && rtc_alarm && supply_ok_threshold && quiet
    |=> on_pulse && st_on) else $error("alarm in off did not start on");
  a_on_gated: assert property (st_off && !supply_ok_threshold |=> !st_on)
    else $error("on without supply ok");
  a_alarm_wake: assert property (st_slp && rtc_alarm && quiet && gpio_req == '0
    && !button_asserted |=> wake_pulse && st_on) else $error("alarm in sleep did not wake");
  a_thermal_off: assert property (st_on && thermal_shutdown && no_rst
    |=> off_pulse && st_off) else $error("thermal shutdown did not power off");
  a_shutdown_off: assert property ((st_on || st_slp) && shutdown_threshold && no_rst
    |=> off_pulse && st_off) else $error("shutdown threshold did not power off");
  a_reset_off: assert property (st_on && hw_reset_req |=> s_reset_off)
    else $error("reset event did not go through off");
  a_reset_on: assert property (st_rst && supply_ok_threshold && quiet |=> s_restart)
    else $error("reset event did not restart");
  a_sleep_step: assert property (sleep_pulse |-> st_slp && $past(power_state) == 2'h1)
    else $error("sleep pulse without on to sleep step");
  a_wake_step: assert property (wake_pulse |-> st_on && $past(power_state) == 2'h3)
    else $error("wake pulse without sleep to on step");
  a_low_no_on: assert property (st_off && low_supply_threshold && !rtc_alarm
    && gpio_req == '0 && !button_asserted && !psel |=> !on_pulse)
    else $error("low supply started an on");
endmodule

/* File: testbench/pste_src_model.sv */
// Model of the event sources outside the device: button, GPIO, monitors.
// Assumes the bench raises fire for exactly one clock per event.
`timescale 1ns/1ps
module pste_src_model (
  input wire logic fire,
  input wire logic [11:0] ev,
  output logic [11:0] pin
);
  // Sources fall back to their idle low level between events
  assign pin = fire ? ev : 12'h000;
endmodule

/* File: testbench/power_state_transition_events_test.sv */
// Self-checking bench for the transition event arbiter.
// Assumes pste_pkg, pste_top, the source model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module power_state_transition_events_test;
  // Row: from state, supply ok, config, gpio function, event, to state, records
  typedef struct packed {
    logic [1:0] f;
    logic s;
    logic [5:0] c;
    logic [2:0] g;
    logic [15:0] e;
    logic [1:0] t;
    logic [15:0] n;
    logic [15:0] o;
  } pste_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sok = 1'b1;
  logic fire = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [2:0] gf = 3'h0;
  logic [11:0] pin;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] q;
  logic e;
  int bad_count = 0;
  int compares = 0;
  // Event bits: 0 alarm 1 gpio 2 button 3 wdog 4 hw rst 5 uv0 6 low 7 shutdown
  // 8 thermal 9 startup 10 int reg 11 uv1; bit 15 means a CTRL write of [14:12]
  pste_row_t rows [0:25] = '{
    '{2'h0, 1'h1, 6'h00, 3'h0, 16'h0001, 2'h1, 16'h8020, 16'h0000},
    '{2'h0, 1'h1, 6'h00, 3'h1, 16'h0002, 2'h1, 16'h8200, 16'h0000},
    '{2'h0, 1'h1, 6'h01, 3'h0, 16'h0004, 2'h1, 16'h8010, 16'h0000},
    '{2'h3, 1'h1, 6'h00, 3'h0, 16'h9000, 2'h1, 16'h0040, 16'h0000},
    '{2'h3, 1'h1, 6'h04, 3'h0, 16'h0008, 2'h1, 16'h0080, 16'h0000},
    '{2'h3, 1'h1, 6'h00, 3'h0, 16'h0001, 2'h1, 16'h0020, 16'h0000},
    '{2'h3, 1'h1, 6'h00, 3'h4, 16'h0002, 2'h1, 16'h0200, 16'h0000},
    '{2'h3, 1'h1, 6'h10, 3'h0, 16'h0040, 2'h1, 16'h0100, 16'h0000},
    '{2'h3, 1'h1, 6'h03, 3'h0, 16'h0004, 2'h1, 16'h0010, 16'h0000},
    '{2'h1, 1'h1, 6'h08, 3'h0, 16'h0008, 2'h1, 16'h0001, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0010, 2'h1, 16'h0002, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'hd000, 2'h1, 16'h0004, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0020, 2'h1, 16'h0008, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0800, 2'h1, 16'h0000, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h8000, 2'h0, 16'h8000, 16'h0040},
    '{2'h1, 1'h1, 6'h02, 3'h0, 16'h0004, 2'h0, 16'h8000, 16'h0010},
    '{2'h1, 1'h1, 6'h20, 3'h0, 16'h0040, 2'h0, 16'h8000, 16'h0400},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0080, 2'h0, 16'h8000, 16'h0400},
    '{2'h1, 1'h1, 6'h00, 3'h2, 16'h0002, 2'h0, 16'h8000, 16'h0800},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0200, 2'h0, 16'h8000, 16'h1000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0400, 2'h0, 16'h8000, 16'h2000},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'h0100, 2'h0, 16'h8000, 16'h0200},
    '{2'h1, 1'h1, 6'h00, 3'h0, 16'hb000, 2'h3, 16'h8000, 16'h0000},
    '{2'h1, 1'h1, 6'h00, 3'h3, 16'h0002, 2'h3, 16'h8000, 16'h0000},
    '{2'h0, 1'h0, 6'h00, 3'h0, 16'h0001, 2'h0, 16'h0000, 16'h0000},
    '{2'h0, 1'h1, 6'h10, 3'h0, 16'h0040, 2'h0, 16'h0000, 16'h0000}
  };

  always #12.5 pclk = ~pclk;

  pste_src_model MDL (.fire(fire), .ev(ev), .pin(pin));

  // Byte strobes are tied high; the top gpio and undervoltage lines stay idle
  pste_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_alarm(pin[0]), .gpio_req({3'h0, pin[1]}),
    .gpio_func({9'h000, gf}), .button_asserted(pin[2]), .watchdog_timeout(pin[3]),
    .hw_reset_req(pin[4]), .reg_undervoltage({6'h00, pin[11], pin[5]}),
    .low_supply_threshold(pin[6]), .shutdown_threshold(pin[7]), .supply_ok_threshold(sok),
    .thermal_shutdown(pin[8]), .startup_timeout(pin[9]), .internal_regulator_fault(pin[10]),
    .power_state(), .on_pulse(), .off_pulse(), .sleep_pulse(), .wake_pulse());

  // One APB transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task stop_test();
    $display("Comparisons %0d, errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 750 cycles the run needs
  initial begin
    repeat (8000) @(posedge pclk);
    bad_count++;
    stop_test();
  end

  // Reset values, an unmapped access, the table, then the sleep record case
  initial begin
    pste_row_t r;
    logic [15:0] m;
    rst();
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
    end
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK(e, 1'b1)
    foreach (rows[i]) begin
      r = rows[i];
      rst();
      gf <= r.g;
      sok <= 1'b1;
      if (r.f != 2'h0) apb(1'b1, pste_pkg::ADDR_CTRL, 32'h0000_0001);
      if (r.f == 2'h3) apb(1'b1, pste_pkg::ADDR_CTRL, 32'h0000_0003);
      apb(1'b1, pste_pkg::ADDR_UVCFG, 32'h0000_0001);
      apb(1'b1, pste_pkg::ADDR_CFG, {26'h000_0000, r.c});
      sok <= r.s;
      if (r.e[15]) begin
        apb(1'b1, pste_pkg::ADDR_CTRL, {29'h0000_0000, r.e[14:12]});
      end else begin
        @(posedge pclk);
        ev <= r.e[11:0];
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      // Restart keeps the reset record; reset rows still compare only bits 11:0
      m = (r.f == 2'h1 && r.t == 2'h1) ? 16'h0fff : 16'hffff;
      apb(1'b0, pste_pkg::ADDR_STATE, 32'h0000_0000);
      `CHK(q[1:0], r.t)
      apb(1'b0, pste_pkg::ADDR_ON_SRC, 32'h0000_0000);
      `CHK(q[15:0] & m, r.n & m)
      apb(1'b0, pste_pkg::ADDR_OFF_SRC, 32'h0000_0000);
      `CHK(q[15:0], r.o)
    end
    rst();
    // Off, on, off, on, then sleep: the software OFF cause must survive
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, pste_pkg::ADDR_CTRL, {30'h0000_0000, 2'(i == 4 ? 3 : i % 2)});
      repeat (3) @(posedge pclk);
    end
    apb(1'b0, pste_pkg::ADDR_OFF_SRC, 32'h0000_0000);
    `CHK(q[15:0], 16'h0040)
    apb(1'b0, pste_pkg::ADDR_STATE, 32'h0000_0000);
    `CHK(q[1:0], 2'h3)
    // Alarm wake leaves the stored sleep bit set; a new sleep write must still work
    @(posedge pclk);
    ev <= 12'h001;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(1'b0, pste_pkg::ADDR_STATE, 32'h0000_0000);
    `CHK(q[1:0], 2'h1)
    apb(1'b1, pste_pkg::ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, pste_pkg::ADDR_STATE, 32'h0000_0000);
    `CHK(q[1:0], 2'h3)
    stop_test();
  end
endmodule

bind pste_top pste_checker #(.NGPIO(NGPIO), .NREG(NREG)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .rtc_alarm(rtc_alarm), .gpio_req(gpio_req),
  .button_asserted(button_asserted), .watchdog_timeout(watchdog_timeout),
  .hw_reset_req(hw_reset_req), .reg_undervoltage(reg_undervoltage),
  .low_supply_threshold(low_supply_threshold), .shutdown_threshold(shutdown_threshold),
  .supply_ok_threshold(supply_ok_threshold), .thermal_shutdown(thermal_shutdown),
  .startup_timeout(startup_timeout), .internal_regulator_fault(internal_regulator_fault),
  .power_state(power_state), .on_pulse(on_pulse), .off_pulse(off_pulse),
  .sleep_pulse(sleep_pulse), .wake_pulse(wake_pulse));
